// *** logic/mic_pkg.sv ***
package mic_pkg;
	// Register selects on the special-function register port
	localparam logic [2:0] ADDR_EDGE = 3'h0;
	localparam logic [2:0] ADDR_CORE = 3'h1;
	localparam logic [2:0] ADDR_TUA = 3'h2;
	localparam logic [2:0] ADDR_TES = 3'h3;
	localparam logic [2:0] ADDR_TB1 = 3'h4;
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] RST_EDGE = 2'h0;
	// Field positions: flags in the upper nibble, enables in the lower
	localparam int FLAG_LSB = 4;
	localparam int ENA_LSB = 0;
	localparam int GIE_BIT = 0;
	// Source numbering, also the static priority (0 = highest)
	localparam int NSRC = 12;
	localparam int SRC_EXT = 0;
	localparam int SRC_PROX = 1;
	localparam int SRC_TOUCH = 2;
	localparam int SRC_ADC = 3;
	localparam int SRC_UART = 4;
	localparam int SRC_CTP = 5;
	localparam int SRC_CTA = 6;
	localparam int SRC_STP = 7;
	localparam int SRC_STA = 8;
	localparam int SRC_EE = 9;
	localparam int SRC_TB0 = 10;
	localparam int SRC_TB1 = 11;
	// Vector spacing in words from the vector base
	localparam int VEC_STEP = 4;
	localparam int VEC_BASE = 4;
	// Edge select field encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// *** logic/mic_irq_ctrl.sv ***
`timescale 1ns/1ps
module mic_irq_ctrl #(
	parameter int PC_W = 13,
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port
	input wire logic [2:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Peripheral event pulses
	input wire logic int_pin_i,
	input wire logic prox_valid_i,
	input wire logic touch_slot_ovf_i,
	input wire logic adc_done_i,
	input wire logic uart_event_i,
	input wire logic compact_timer_match_p_i,
	input wire logic compact_timer_match_a_i,
	input wire logic standard_timer_match_p_i,
	input wire logic standard_timer_match_a_i,
	input wire logic eeprom_write_done_i,
	input wire logic timebase_zero_i,
	input wire logic timebase_one_i,
	// Pin pull-high request from the port logic
	input wire logic pin_pullup_sel_i,
	output logic pin_pullup_en_o,
	// Core sequencer
	input wire logic [PC_W-1:0] next_pc_i,
	input wire logic instr_boundary_i,
	input wire logic return_from_irq_instr_i,
	input wire logic call_push_i,
	input wire logic ret_pop_i,
	input wire logic sleep_idle_i,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_value_o,
	output logic irq_taken_o,
	output logic stack_full_o,
	output logic wake_o
);
	import mic_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH + 1);

	typedef struct packed {
		logic [NSRC-1:0] flag;
		logic [NSRC-1:0] ena;
		logic gie;
		logic [1:0] edge_sel;
		logic pin_q;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic pc_load;
		logic [PC_W-1:0] pc_value;
		logic taken;
		logic wake;
		logic [7:0] rdata;
	} mic_state_type;

	mic_state_type s_q;
	mic_state_type s_d;

	logic [NSRC-1:0] evt;
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] win;
	logic pin_edge;
	logic full;

	// Pack four flags and four enables into a byte, flags in the top nibble
	function automatic logic [7:0] mic_pack(input logic [3:0] f, input logic [3:0] e);
		return {f, e};
	endfunction

	// Vector address of a source, spaced by its priority index.
	// Vector order and priority order are one list, so a lower
	// address always means a higher priority.
	function automatic logic [PC_W-1:0] mic_vector(input int idx);
		return PC_W'(VEC_BASE + idx * VEC_STEP);
	endfunction

	// The pin is taken as synchronous, so a single previous sample
	// is enough for edge detection. An asynchronous pin needs a
	// synchroniser in front of this block.
	// edge decode against the previous pin sample
	always_comb begin
		case (s_q.edge_sel)
			EDGE_RISE: pin_edge = int_pin_i & ~s_q.pin_q;
			EDGE_FALL: pin_edge = ~int_pin_i & s_q.pin_q;
			EDGE_BOTH: pin_edge = int_pin_i ^ s_q.pin_q;
			default: pin_edge = 1'b0;
		endcase
	end

	// Events are one-cycle pulses from the peripherals; a level held
	// high keeps setting the flag, which only hides a software clear.
	// Enables never gate the set, so a disabled source still records.
	// every event sets its flag, enable or not
	assign evt[SRC_EXT] = pin_edge;
	assign evt[SRC_PROX] = prox_valid_i;
	assign evt[SRC_TOUCH] = touch_slot_ovf_i;
	assign evt[SRC_ADC] = adc_done_i;
	assign evt[SRC_UART] = uart_event_i;
	assign evt[SRC_CTP] = compact_timer_match_p_i;
	assign evt[SRC_CTA] = compact_timer_match_a_i;
	assign evt[SRC_STP] = standard_timer_match_p_i;
	assign evt[SRC_STA] = standard_timer_match_a_i;
	assign evt[SRC_EE] = eeprom_write_done_i;
	assign evt[SRC_TB0] = timebase_zero_i;
	assign evt[SRC_TB1] = timebase_one_i;

	assign full = (s_q.sp == SP_W'(STACK_DEPTH));

	// A flag with its enable low stays set and simply waits here.
	// Clearing the global enable parks every source at once.
	// only enabled flags with global enable may request
	assign pend = s_q.flag & s_q.ena & {NSRC{s_q.gie}};

	// lowest index wins; isolate the lowest set bit
	assign win = pend & (~pend + NSRC'(1));

	always_comb begin
		s_d = s_q;
		s_d.pin_q = int_pin_i;
		s_d.pc_load = 1'b0;
		s_d.taken = 1'b0;
		// register writes act directly on flags and enables
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_EDGE: s_d.edge_sel = reg_wdata_i[1:0];
				ADDR_CORE: begin
					s_d.flag[SRC_TOUCH] = reg_wdata_i[6];
					s_d.flag[SRC_PROX] = reg_wdata_i[5];
					s_d.flag[SRC_EXT] = reg_wdata_i[4];
					s_d.ena[SRC_TOUCH] = reg_wdata_i[3];
					s_d.ena[SRC_PROX] = reg_wdata_i[2];
					s_d.ena[SRC_EXT] = reg_wdata_i[1];
					s_d.gie = reg_wdata_i[GIE_BIT];
				end
				ADDR_TUA: begin
					{s_d.flag[SRC_CTA], s_d.flag[SRC_CTP], s_d.flag[SRC_UART], s_d.flag[SRC_ADC]} =
						reg_wdata_i[FLAG_LSB+:4];
					{s_d.ena[SRC_CTA], s_d.ena[SRC_CTP], s_d.ena[SRC_UART], s_d.ena[SRC_ADC]} =
						reg_wdata_i[ENA_LSB+:4];
				end
				// time base 0, EEPROM, standard timer
				ADDR_TES: begin
					{s_d.flag[SRC_TB0], s_d.flag[SRC_EE], s_d.flag[SRC_STA], s_d.flag[SRC_STP]} =
						reg_wdata_i[FLAG_LSB+:4];
					{s_d.ena[SRC_TB0], s_d.ena[SRC_EE], s_d.ena[SRC_STA], s_d.ena[SRC_STP]} =
						reg_wdata_i[ENA_LSB+:4];
				end
				// only bits 4 and 0 are kept
				ADDR_TB1: begin
					s_d.flag[SRC_TB1] = reg_wdata_i[FLAG_LSB];
					s_d.ena[SRC_TB1] = reg_wdata_i[ENA_LSB];
				end
				default: ;
			endcase
		end
		// Calls, returns and interrupt entry share one stack and one
		// pointer. A call wins over a return, and a return over an
		// interrupt, so the core never sees two stack moves at once.
		// A call on a full stack is dropped; the core must not issue
		// one, as the return address would be lost.
		// Subroutine call and return move the shared stack pointer
		if (call_push_i && !full) begin
			s_d.stack[s_q.sp[SP_W-1:0]] = next_pc_i;
			s_d.sp = s_q.sp + SP_W'(1);
		end else if ((ret_pop_i || return_from_irq_instr_i) && s_q.sp != '0) begin
			// pop the saved address back into the program counter
			s_d.sp = s_q.sp - SP_W'(1);
			s_d.pc_load = 1'b1;
			s_d.pc_value = s_q.stack[s_q.sp - SP_W'(1)];
		end else if (instr_boundary_i && !call_push_i && !ret_pop_i && !return_from_irq_instr_i && !full && pend != '0) begin
			// Entry is a hardware call: the stack takes the next address,
			// the vector of the single winning source goes to the core.
			// A return on an empty stack still blocks entry that cycle.
			// push next address, jump to the winner's vector
			s_d.stack[s_q.sp[SP_W-1:0]] = next_pc_i;
			s_d.sp = s_q.sp + SP_W'(1);
			s_d.pc_load = 1'b1;
			s_d.taken = 1'b1;
			for (int i = 0; i < NSRC; i++) begin
				if (win[i]) begin
					s_d.pc_value = mic_vector(i);
				end
			end
			// block nesting and drop the serviced flag
			s_d.gie = 1'b0;
			s_d.flag = s_d.flag & ~win;
		end
		// hardware set wins over any clear this cycle
		s_d.flag = s_d.flag | evt;
		// Wake looks at the rise of any flag, enable or not; a flag
		// already high before sleep therefore cannot wake the core.
		// wake only on a flag that rises while asleep
		s_d.wake = sleep_idle_i & |(s_d.flag & ~s_q.flag);
		// Registered read data, bits without storage read zero
		// Read data lags the select by one cycle
		case (reg_addr_i)
			// Only the two low bits are stored
			ADDR_EDGE: begin
				s_d.rdata = {6'h00, s_q.edge_sel};
			end
			// Bit 7 has no storage
			ADDR_CORE: begin
				s_d.rdata = {
					1'b0,
					s_q.flag[SRC_TOUCH],
					s_q.flag[SRC_PROX],
					s_q.flag[SRC_EXT],
					s_q.ena[SRC_TOUCH],
					s_q.ena[SRC_PROX],
					s_q.ena[SRC_EXT],
					s_q.gie
				};
			end
			// Flags in the top nibble, enables below, same source order
			ADDR_TUA: begin
				s_d.rdata = mic_pack(
					{s_q.flag[SRC_CTA], s_q.flag[SRC_CTP], s_q.flag[SRC_UART], s_q.flag[SRC_ADC]},
					{s_q.ena[SRC_CTA], s_q.ena[SRC_CTP], s_q.ena[SRC_UART], s_q.ena[SRC_ADC]}
				);
			end
			ADDR_TES: begin
				s_d.rdata = mic_pack(
					{s_q.flag[SRC_TB0], s_q.flag[SRC_EE], s_q.flag[SRC_STA], s_q.flag[SRC_STP]},
					{s_q.ena[SRC_TB0], s_q.ena[SRC_EE], s_q.ena[SRC_STA], s_q.ena[SRC_STP]}
				);
			end
			// Only bits 4 and 0 exist
			ADDR_TB1: begin
				s_d.rdata = mic_pack({3'h0, s_q.flag[SRC_TB1]}, {3'h0, s_q.ena[SRC_TB1]});
			end
			// Unmapped selects read zero
			default: begin
				s_d.rdata = RST_REG;
			end
		endcase
	end

	// Single state register; pin sample starts low so no edge is seen at reset
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.edge_sel <= RST_EDGE;
			s_q.rdata <= RST_REG;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register, except the pull-high
	// enable and the stack full flag, which the core needs in the same cycle.
	// pull-high selection passes through regardless of pin use
	assign pin_pullup_en_o = pin_pullup_sel_i;
	assign reg_rdata_o = s_q.rdata;
	assign pc_load_o = s_q.pc_load;
	assign pc_value_o = s_q.pc_value;
	assign irq_taken_o = s_q.taken;
	assign stack_full_o = full;
	assign wake_o = s_q.wake;
endmodule

// *** verif/mic_irq_ctrl_monitor.sv ***
`timescale 1ns/1ps
module mic_irq_ctrl_monitor import mic_pkg::*; #(
	parameter int PC_W = 13,
	parameter int STACK_DEPTH = 8
) (
	// Watched ports
	input wire logic clock_i, rst_i, pin_pullup_sel_i, pin_pullup_en_o, instr_boundary_i, return_from_irq_instr_i, call_push_i,
	input wire logic ret_pop_i, sleep_idle_i, pc_load_o, irq_taken_o, stack_full_o, wake_o,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [PC_W-1:0] pc_value_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Entry pulse and the conditions that forbid one
	sequence s_entry;
		irq_taken_o && pc_load_o;
	endsequence
	sequence s_blocked;
		!instr_boundary_i || call_push_i || return_from_irq_instr_i || ret_pop_i;
	endsequence
	a_pullup_kept: assert property (pin_pullup_en_o == pin_pullup_sel_i) else $error("pullup lost");
	a_entry_vector: assert property (irq_taken_o |-> s_entry ##0 pc_value_o[1:0] == 2'h0
		&& pc_value_o >= VEC_BASE && pc_value_o <= VEC_BASE + VEC_STEP * (NSRC - 1)) else $error("bad vector");
	a_single_entry: assert property (s_entry |=> !irq_taken_o) else $error("nested entry");
	a_need_boundary: assert property (s_blocked |=> !irq_taken_o) else $error("entry off boundary");
	a_full_blocks: assert property (stack_full_o |=> !irq_taken_o) else $error("entry on full stack");
	a_wake_sleep: assert property (wake_o |-> $past(sleep_idle_i)) else $error("wake while awake");
	a_tb1_reserved: assert property ($past(reg_addr_i) == ADDR_TB1 |-> (reg_rdata_o & 8'hee) == 8'h00)
		else $error("reserved bits set");
	a_edge_reserved: assert property ($past(reg_addr_i) == ADDR_EDGE |-> reg_rdata_o[7:2] == 6'h00)
		else $error("edge reserved set");
	a_core_bit7: assert property ($past(reg_addr_i) == ADDR_CORE |-> !reg_rdata_o[7]) else $error("bit 7 set");
endmodule

// *** verif/mic_core_model.sv ***
`timescale 1ns/1ps
module mic_core_model #(
	parameter int PC_W = 13
) (
	// Clock and control
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic run_i,
	// Controller answers
	input wire logic pc_load_i,
	input wire logic [PC_W-1:0] pc_value_i,
	input wire logic irq_taken_i,
	// Sequencer outputs
	output logic instr_boundary_o,
	output logic [PC_W-1:0] next_pc_o,
	output int n_taken_o
);
	// Next address moves only on a load, so a pushed value stays known
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			next_pc_o <= PC_W'(16'h0100);
			n_taken_o <= 0;
		end else begin
			if (pc_load_i)
				next_pc_o <= pc_value_i + 1'b1;
			if (irq_taken_i)
				n_taken_o <= n_taken_o + 1;
		end
	end
	assign instr_boundary_o = run_i;
endmodule

// *** verif/mic_irq_ctrl_tb.sv ***
`timescale 1ns/1ps
module mic_irq_ctrl_tb;
	import mic_pkg::*;
	logic clock_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, int_pin_i = 1'b0, pin_pullup_sel_i = 1'b0, run = 1'b0;
	logic return_from_irq_instr_i = 1'b0, call_push_i = 1'b0, ret_pop_i = 1'b0, sleep_idle_i = 1'b0;
	logic instr_boundary_i, pin_pullup_en_o, pc_load_o, irq_taken_o, stack_full_o, wake_o;
	logic [2:0] reg_addr_i = 3'h0;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, cf;
	logic [11:0] ev = 12'h000;
	logic [12:0] next_pc_i, pc_value_o, pc_saved;
	int failures = 0, n_compared = 0, cyc = 0, n_wake = 0, n_taken;
	mic_irq_ctrl #(.STACK_DEPTH(8)) uut (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
		.int_pin_i, .prox_valid_i(ev[SRC_PROX]), .touch_slot_ovf_i(ev[SRC_TOUCH]), .adc_done_i(ev[SRC_ADC]),
		.uart_event_i(ev[SRC_UART]), .compact_timer_match_p_i(ev[SRC_CTP]), .compact_timer_match_a_i(ev[SRC_CTA]),
		.standard_timer_match_p_i(ev[SRC_STP]), .standard_timer_match_a_i(ev[SRC_STA]),
		.eeprom_write_done_i(ev[SRC_EE]), .timebase_zero_i(ev[SRC_TB0]), .timebase_one_i(ev[SRC_TB1]),
		.pin_pullup_sel_i, .pin_pullup_en_o, .next_pc_i, .instr_boundary_i, .return_from_irq_instr_i, .call_push_i, .ret_pop_i,
		.sleep_idle_i, .pc_load_o, .pc_value_o, .irq_taken_o, .stack_full_o, .wake_o);
	mic_core_model core (.clock_i, .rst_i, .run_i(run), .pc_load_i(pc_load_o), .pc_value_i(pc_value_o),
		.irq_taken_i(irq_taken_o), .instr_boundary_o(instr_boundary_i), .next_pc_o(next_pc_i), .n_taken_o(n_taken));
	always #2 clock_i = ~clock_i;
	// Wake pulses counted; the ceiling cuts a hang short
	always @(posedge clock_i) begin
		n_wake <= n_wake + (wake_o === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			finish_test;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	// Two extra edges of margin cover the registered read path
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock_i);
		reg_addr_i <= a;
		repeat (3) @(posedge clock_i);
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic pulse(input int i);
		@(posedge clock_i);
		ev[i] <= 1'b1;
		@(posedge clock_i);
		ev[i] <= 1'b0;
	endtask
	task automatic wait_load(input logic [15:0] e);
		#1;
		for (int k = 0; k < 20 && pc_load_o !== 1'b1; k++)
			@(posedge clock_i) #1;
		chk({15'h0000, pc_load_o}, 16'h0001);
		chk(pc_value_o, e);
	endtask
	task automatic t_regs;
		for (int a = 0; a < 6; a++)
			rd(3'(a), 8'h00);
		for (int a = 0; a < 6; a++) begin
			wr(3'(a), 8'hff);
			rd(3'(a), (a == 0) ? 8'h03 : (a == 1) ? 8'h7f : (a == 4) ? 8'h11 : (a > 4) ? 8'h00 : 8'hff);
			wr(3'(a), 8'h00);
		end
	endtask
	// Second pulse of a set flag must not wake again
	task automatic t_events;
		logic [2:0] a;
		sleep_idle_i <= 1'b1;
		for (int i = 1; i < NSRC; i++) begin
			a = (i < 3) ? ADDR_CORE : (i < 7) ? ADDR_TUA : (i < 11) ? ADDR_TES : ADDR_TB1;
			pulse(i);
			pulse(i);
			rd(a, 8'h10 << ((i < 3) ? i : (i < 7) ? i - 3 : (i < 11) ? i - 7 : 0));
			wr(a, 8'h00);
		end
		chk(n_wake, 11);
		sleep_idle_i <= 1'b0;
	endtask
	task automatic t_edge;
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_EDGE, 8'(m));
			wr(ADDR_CORE, 8'h02);
			@(posedge clock_i);
			int_pin_i <= 1'b1;
			pin_pullup_sel_i <= m[0];
			rd(ADDR_CORE, m[0] ? 8'h12 : 8'h02);
			wr(ADDR_CORE, 8'h02);
			@(posedge clock_i);
			int_pin_i <= 1'b0;
			rd(ADDR_CORE, m[1] ? 8'h12 : 8'h02);
		end
	endtask
	task automatic t_prio;
		wr(ADDR_CORE, 8'h7e);
		wr(ADDR_TUA, 8'hff);
		wr(ADDR_TES, 8'hff);
		wr(ADDR_TB1, 8'h11);
		run <= 1'b1;
		repeat (5) @(posedge clock_i);
		chk(n_taken, 0);
		cf = 8'h70;
		for (int i = 0; i < NSRC; i++) begin
			run <= 1'b0;
			wr(ADDR_CORE, cf | 8'h0f);
			pc_saved = next_pc_i;
			run <= 1'b1;
			wait_load(16'(VEC_BASE + VEC_STEP * i));
			if (i < 3)
				cf[4 + i] = 1'b0;
			@(posedge clock_i);
			run <= 1'b0;
			return_from_irq_instr_i <= 1'b1;
			@(posedge clock_i);
			return_from_irq_instr_i <= 1'b0;
			wait_load(16'(pc_saved));
		end
		rd(ADDR_TUA, 8'h0f);
		chk(n_taken, NSRC);
	endtask
	// Fill the stack, then one pop lets the held request in
	task automatic t_stack;
		@(posedge clock_i);
		call_push_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		call_push_i <= 1'b0;
		pc_saved = next_pc_i;
		wr(ADDR_TUA, 8'h11);
		wr(ADDR_CORE, 8'h01);
		chk(stack_full_o, 1'b1);
		run <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(n_taken, NSRC);
		run <= 1'b0;
		ret_pop_i <= 1'b1;
		@(posedge clock_i);
		ret_pop_i <= 1'b0;
		wait_load(16'(pc_saved));
		@(posedge clock_i);
		run <= 1'b1;
		wait_load(16'(VEC_BASE + VEC_STEP * SRC_ADC));
	endtask
	task automatic finish_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs;
		t_events;
		t_edge;
		t_prio;
		t_stack;
		finish_test;
	end
endmodule
bind mic_irq_ctrl mic_irq_ctrl_monitor #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) mon (.clock_i, .rst_i,
	.pin_pullup_sel_i, .pin_pullup_en_o, .instr_boundary_i, .return_from_irq_instr_i, .call_push_i, .ret_pop_i, .sleep_idle_i,
	.pc_load_o, .irq_taken_o, .stack_full_o, .wake_o, .reg_addr_i, .reg_rdata_o, .pc_value_o);
